/* rfaf_pkg.sv */
// Summary of operation
// R1: ATM mode: flag high while the FIFO holds two or more complete cells, or one whose selected payload byte is not yet read.
// R2: ATM mode: on the last cell, flag drops after the selected payload byte.
// R3: The deassert point lets the reader see the last cell early.
// R4: POS mode: flag high on a held end-of-packet or words at watermark.
// R5: POS mode: flag low only with no end-of-packet and words below watermark.
// R6: Each flag changes only on its own receive interface clock edge.
// R7: Each flag output is always actively driven.
// R8: ATM or POS mode is a static setting while the interface runs.
package rfaf_pkg;
  localparam int unsigned CH_N        = 4;
  localparam int unsigned DP_W        = 6;
  localparam int unsigned CNT_W       = 8;
  localparam int unsigned WM_W        = 16;
  localparam int unsigned IDX_W       = 6;
  localparam logic [IDX_W-1:0] HDR_BYTES  = 6'h05;
  localparam logic [IDX_W-1:0] CELL_LAST  = 6'h34;
  localparam logic [DP_W-1:0]  DP_MIN     = 6'h01;
  localparam logic [DP_W-1:0]  DP_MAX     = 6'h30;
  localparam logic [1:0]       WORD_LAST  = 2'h3;
  localparam logic             FLAG_RST   = 1'b0;
  localparam logic [CNT_W-1:0] CELLS_RST  = 8'h00;
  localparam logic [WM_W-1:0]  WORDS_RST  = 16'h0000;
  localparam logic [IDX_W-1:0] IDX_RST    = 6'h00;
endpackage

/* rfaf_xfer_if.sv */
`timescale 1ns/1ns
interface rfaf_xfer_if;
  logic                            cell_tgl;
  logic                            word_tgl;
  logic                            eop_tgl;
  logic                            mode_pos;
  logic [rfaf_pkg::DP_W-1:0]       dp;
  logic [rfaf_pkg::WM_W-1:0]       wm;
  modport src (output cell_tgl, output word_tgl, output eop_tgl,
               output mode_pos, output dp, output wm);
  modport dst (input cell_tgl, input word_tgl, input eop_tgl,
               input mode_pos, input dp, input wm);
endinterface

/* rfaf_evt_sync.sv */
`timescale 1ns/1ns
module rfaf_evt_sync (
  input  wire logic                      link_clk_i,
  input  wire logic                      reset_n_i,
  rfaf_xfer_if.dst                       xfer,
  output logic                           cell_ev_o,
  output logic                           word_ev_o,
  output logic                           eop_ev_o,
  output logic                           mode_pos_o,
  output logic [rfaf_pkg::DP_W-1:0]      dp_o,
  output logic [rfaf_pkg::WM_W-1:0]      wm_o
);
  logic [2:0] tgl_s1_r;
  logic [2:0] tgl_s2_r;
  logic [2:0] tgl_s3_r;
  logic                        mode_s1_r;
  logic [rfaf_pkg::DP_W-1:0]   dp_s1_r;
  logic [rfaf_pkg::WM_W-1:0]   wm_s1_r;

  // ==========================================================
  // Event toggles: two flops, then a third for edge detection
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tgl_s1_r <= 3'h0;
      tgl_s2_r <= 3'h0;
      tgl_s3_r <= 3'h0;
    end else begin
      tgl_s1_r <= {xfer.eop_tgl, xfer.word_tgl, xfer.cell_tgl};
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  assign cell_ev_o = tgl_s2_r[0] ^ tgl_s3_r[0];
  assign word_ev_o = tgl_s2_r[1] ^ tgl_s3_r[1];
  assign eop_ev_o  = tgl_s2_r[2] ^ tgl_s3_r[2];

  // ==========================================================
  // Static settings: plain level sync, safe only because they hold still
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_s1_r  <= 1'b0;
      mode_pos_o <= 1'b0;
      dp_s1_r    <= rfaf_pkg::DP_MAX;
      dp_o       <= rfaf_pkg::DP_MAX;
      wm_s1_r    <= rfaf_pkg::WORDS_RST;
      wm_o       <= rfaf_pkg::WORDS_RST;
    end else begin
      mode_s1_r  <= xfer.mode_pos; // see R8
      mode_pos_o <= mode_s1_r;
      dp_s1_r    <= xfer.dp;
      dp_o       <= dp_s1_r;
      wm_s1_r    <= xfer.wm;
      wm_o       <= wm_s1_r;
    end
  end
endmodule

/* rfaf_top.sv */
`timescale 1ns/1ns
module rfaf_top #(
  parameter int unsigned CH_N = rfaf_pkg::CH_N
) (
  input  wire logic                          clk_i,
  input  wire logic                          reset_n_i,
  input  wire logic [CH_N-1:0]               wr_cell_i,
  input  wire logic [CH_N-1:0]               wr_word_i,
  input  wire logic [CH_N-1:0]               wr_eop_i,
  input  wire logic [CH_N-1:0]               mode_pos_i,
  input  wire logic [CH_N*rfaf_pkg::DP_W-1:0] cell_avail_deassert_point_i,
  input  wire logic [CH_N*rfaf_pkg::WM_W-1:0] watermark_i,
  input  wire logic [CH_N-1:0]               rx_iface_clock_i,
  input  wire logic [CH_N-1:0]               rd_i,
  input  wire logic [CH_N-1:0]               rd_eop_i,
  output logic      [CH_N-1:0]               rx_frame_available_o
);
  genvar g;
  generate
    for (g = 0; g < CH_N; g = g + 1) begin : gen_ch
      rfaf_xfer_if xfer ();
      logic                          cell_tgl_r;
      logic                          word_tgl_r;
      logic                          eop_tgl_r;
      logic                          cell_ev;
      logic                          word_ev;
      logic                          eop_ev;
      logic                          mode_pos;
      logic [rfaf_pkg::DP_W-1:0]     dp;
      logic [rfaf_pkg::DP_W-1:0]     dp_eff;
      logic [rfaf_pkg::WM_W-1:0]     wm;
      logic [rfaf_pkg::CNT_W-1:0]    cells_r;
      logic [rfaf_pkg::CNT_W-1:0]    cells_nxt;
      logic [rfaf_pkg::WM_W-1:0]     words_r;
      logic [rfaf_pkg::WM_W-1:0]     words_nxt;
      logic [rfaf_pkg::CNT_W-1:0]    eops_r;
      logic [rfaf_pkg::CNT_W-1:0]    eops_nxt;
      logic [rfaf_pkg::IDX_W-1:0]    idx_r;
      logic [1:0]                    wbyte_r;
      logic                          past_dp_r;
      logic                          past_dp_nxt;
      logic                          atm_rd;
      logic                          pos_rd;
      logic                          cell_done;
      logic                          word_done;
      logic                          dp_hit;
      logic                          flag_r;
      logic                          flag_nxt;

      // ==========================================================
      // Write side events, core clock: one toggle per event
      // Limitation: at most one event of each kind per core clock
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          cell_tgl_r <= 1'b0;
          word_tgl_r <= 1'b0;
          eop_tgl_r  <= 1'b0;
        end else begin
          cell_tgl_r <= cell_tgl_r ^ wr_cell_i[g];
          word_tgl_r <= word_tgl_r ^ wr_word_i[g];
          eop_tgl_r  <= eop_tgl_r ^ wr_eop_i[g];
        end
      end

      assign xfer.cell_tgl = cell_tgl_r;
      assign xfer.word_tgl = word_tgl_r;
      assign xfer.eop_tgl  = eop_tgl_r;
      assign xfer.mode_pos = mode_pos_i[g];
      assign xfer.dp       = cell_avail_deassert_point_i[g*rfaf_pkg::DP_W +: rfaf_pkg::DP_W];
      assign xfer.wm       = watermark_i[g*rfaf_pkg::WM_W +: rfaf_pkg::WM_W];

      rfaf_evt_sync u_sync (
        .link_clk_i (rx_iface_clock_i[g]),
        .reset_n_i  (reset_n_i),
        .xfer       (xfer.dst),
        .cell_ev_o  (cell_ev),
        .word_ev_o  (word_ev),
        .eop_ev_o   (eop_ev),
        .mode_pos_o (mode_pos),
        .dp_o       (dp),
        .wm_o       (wm)
      );

      // ==========================================================
      // Read side decode, link clock; reads of an empty FIFO are ignored
      always_comb begin
        if (dp < rfaf_pkg::DP_MIN || dp > rfaf_pkg::DP_MAX) begin
          dp_eff = rfaf_pkg::DP_MAX;
        end else begin
          dp_eff = dp;
        end
      end

      assign atm_rd    = !mode_pos && rd_i[g] && (cells_r != rfaf_pkg::CELLS_RST);
      assign pos_rd    = mode_pos && rd_i[g] && (words_r != rfaf_pkg::WORDS_RST);
      assign cell_done = atm_rd && (idx_r == rfaf_pkg::CELL_LAST);
      assign word_done = pos_rd && ((wbyte_r == rfaf_pkg::WORD_LAST) || rd_eop_i[g]);
      // Payload byte dp sits at index HDR_BYTES + dp - 1
      assign dp_hit    = atm_rd && (idx_r == rfaf_pkg::IDX_W'(rfaf_pkg::HDR_BYTES + dp_eff - 6'h01));

      always_comb begin
        cells_nxt = cells_r + rfaf_pkg::CNT_W'(cell_ev) - rfaf_pkg::CNT_W'(cell_done);
        words_nxt = words_r + rfaf_pkg::WM_W'(word_ev) - rfaf_pkg::WM_W'(word_done);
        eops_nxt  = eops_r + rfaf_pkg::CNT_W'(eop_ev) - rfaf_pkg::CNT_W'(pos_rd && rd_eop_i[g]);
        past_dp_nxt = past_dp_r;
        if (dp_hit) begin
          past_dp_nxt = 1'b1;
        end
        if (cell_done) begin
          past_dp_nxt = 1'b0;
        end
      end

      // ==========================================================
      // Occupancy counters on the channel's own clock
      always_ff @(posedge rx_iface_clock_i[g] or negedge reset_n_i) begin
        if (!reset_n_i) begin
          cells_r   <= rfaf_pkg::CELLS_RST;
          words_r   <= rfaf_pkg::WORDS_RST;
          eops_r    <= rfaf_pkg::CELLS_RST;
          idx_r     <= rfaf_pkg::IDX_RST;
          wbyte_r   <= 2'h0;
          past_dp_r <= 1'b0;
        end else begin
          cells_r   <= cells_nxt;
          words_r   <= words_nxt;
          eops_r    <= eops_nxt;
          past_dp_r <= past_dp_nxt;
          if (cell_done) begin
            idx_r <= rfaf_pkg::IDX_RST;
          end else if (atm_rd) begin
            idx_r <= idx_r + 6'h01;
          end
          if (word_done) begin
            wbyte_r <= 2'h0;
          end else if (pos_rd) begin
            wbyte_r <= wbyte_r + 2'h1;
          end
        end
      end

      // ==========================================================
      // Frame-available flag
      always_comb begin
        if (mode_pos) begin
          // Set and clear are exact complements of each other
          flag_nxt = (eops_nxt != rfaf_pkg::CELLS_RST) || (words_nxt >= wm); // see R4 see R5
        end else begin
          // Early drop on the last cell gives the reader warning before its end
          flag_nxt = (cells_nxt > 8'h01) ||
                     ((cells_nxt == 8'h01) && !past_dp_nxt); // see R1 see R2 see R3
        end
      end

      always_ff @(posedge rx_iface_clock_i[g] or negedge reset_n_i) begin
        if (!reset_n_i) begin
          flag_r <= rfaf_pkg::FLAG_RST;
        end else begin
          flag_r <= flag_nxt; // see R6
        end
      end

      assign rx_frame_available_o[g] = flag_r; // see R7
    end
  endgenerate
endmodule

/* rfaf_chk.sv */
`timescale 1ns/1ns
module rfaf_chk #(
  parameter int unsigned CH_N = 4
) (
  input wire logic                        clk_i,
  input wire logic                        reset_n_i,
  input wire logic [CH_N-1:0]             mode_pos_i,
  input wire logic [CH_N*16-1:0]          watermark_i,
  input wire logic [CH_N-1:0]             rx_iface_clock_i,
  input wire logic [CH_N-1:0]             rd_i,
  input wire logic [CH_N-1:0]             rx_frame_available_o
);
  wire logic            k0 = rx_iface_clock_i[0];
  wire logic            k3 = rx_iface_clock_i[3];
  wire logic [CH_N-1:0] fa = rx_frame_available_o;
  logic                 fa0_mid_r;
  logic                 fa1_mid_r;
  // ==========
  // Flag taken at the falling link edge; any change before the next rising edge is off-clock
  always_ff @(negedge k0 or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fa0_mid_r <= 1'b0;
    end else begin
      fa0_mid_r <= fa[0];
    end
  end
  always_ff @(negedge rx_iface_clock_i[1] or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fa1_mid_r <= 1'b0;
    end else begin
      fa1_mid_r <= fa[1];
    end
  end
  // ==========
  // Flag checks
  a_flag_low_reset: assert property (@(posedge k0) disable iff (!reset_n_i)
    !$past(reset_n_i) |-> fa == '0) else $error("flag high after reset");
  a_atm_drop_read: assert property (@(posedge k0) disable iff (!reset_n_i)
    !mode_pos_i[0] && $fell(fa[0]) |-> $past(rd_i[0])) else $error("drop without read");
  a_pos_drop_read: assert property (@(posedge k0) disable iff (!reset_n_i)
    mode_pos_i[0] && $fell(fa[0]) |-> $past(rd_i[0])) else $error("drop without read");
  a_noread_hold0: assert property (@(posedge k0) disable iff (!reset_n_i)
    fa[0] && !rd_i[0] |=> fa[0]) else $error("flag 0 fell while idle");
  a_noread_hold1: assert property (@(posedge rx_iface_clock_i[1])
    disable iff (!reset_n_i) fa[1] && !rd_i[1] |=> fa[1]) else $error("flag 1 fell");
  a_wm0_always_high: assert property (@(posedge k3) disable iff (!reset_n_i)
    reset_n_i [*6] ##1 mode_pos_i[3] && ~|watermark_i[48 +: 16] |-> fa[3])
    else $error("flag 3 low at zero watermark");
  a_ch0_own_clock: assert property (@(posedge k0) disable iff (!reset_n_i)
    fa[0] == fa0_mid_r) else $error("flag 0 off its clock");
  a_ch1_own_clock: assert property (@(posedge rx_iface_clock_i[1])
    disable iff (!reset_n_i) fa[1] == fa1_mid_r) else $error("flag 1 off its clock");
endmodule
bind rfaf_top rfaf_chk #(.CH_N(CH_N)) i_rfaf_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .mode_pos_i(mode_pos_i), .watermark_i(watermark_i), .rx_iface_clock_i(rx_iface_clock_i),
  .rd_i(rd_i), .rx_frame_available_o(rx_frame_available_o));

/* rfaf_reader.sv */
`timescale 1ns/1ns
module rfaf_reader (
  input  wire logic rclk_i,
  output logic      rd_o,
  output logic      rd_eop_o
);
  initial begin
    rd_o = 1'b0;
    rd_eop_o = 1'b0;
  end
  // ==========
  // One byte per edge; slow mode idles every other edge with a junk end mark
  task automatic read_bytes(input int n, input bit eop, input bit slow);
    for (int i = 0; i < n; i++) begin
      @(posedge rclk_i);
      rd_o <= 1'b1;
      rd_eop_o <= eop && (i == n - 1);
      if (slow) begin
        @(posedge rclk_i);
        rd_o <= 1'b0;
        rd_eop_o <= ~rd_eop_o;
      end
    end
    @(posedge rclk_i);
    rd_o <= 1'b0;
    rd_eop_o <= 1'b0;
    // Return at the falling edge so the flag launched by the last byte has settled
    @(negedge rclk_i);
  endtask
endmodule

/* rx_fifo_frame_available_flag_tb_top.sv */
`timescale 1ns/1ns
module rx_fifo_frame_available_flag_tb_top;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [3:0]  rx_clk = 4'h5;
  logic [3:0]  wr_cell = 4'h0;
  logic [3:0]  wr_word = 4'h0;
  logic [3:0]  wr_eop = 4'h0;
  logic [3:0]  mode_pos = 4'h8;
  logic [23:0] dp = 24'hC30C30;
  logic [63:0] wm = 64'h0000000300030003;
  logic        rd0;
  logic        rde0;
  logic [3:0]  fa;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  initial forever #20 clk_i = ~clk_i;
  initial begin
    #5;
    forever #16 rx_clk = ~rx_clk;
  end
  rfaf_top i_rfaf_top (.clk_i(clk_i), .reset_n_i(reset_n_i), .wr_cell_i(wr_cell),
    .wr_word_i(wr_word), .wr_eop_i(wr_eop), .mode_pos_i(mode_pos),
    .cell_avail_deassert_point_i(dp), .watermark_i(wm), .rx_iface_clock_i(rx_clk),
    .rd_i({3'h0, rd0}), .rd_eop_i({3'h0, rde0}), .rx_frame_available_o(fa));
  rfaf_reader i_rfaf_reader (.rclk_i(rx_clk[0]), .rd_o(rd0), .rd_eop_o(rde0));
  // ==========
  // Shared tasks
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(input logic [3:0] c, input logic [3:0] w, input logic [3:0] e, int n);
    repeat (n) begin
      @(posedge clk_i);
      wr_cell <= c;
      wr_word <= w;
      wr_eop <= e;
    end
    @(posedge clk_i);
    {wr_cell, wr_word, wr_eop} <= 12'h000;
  endtask
  task automatic lwait(input int n);
    repeat (n) @(posedge rx_clk[0]);
    #1;
  endtask
  task automatic final_report;
    $display("Checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========
  // Scenarios; a drop point of 44 leaves four bytes after the drop
  task automatic test_atm;
    int d[3] = '{1, 44, 48};
    foreach (d[k]) begin
      @(posedge clk_i);
      dp[5:0] <= d[k][5:0];
      pulse(4'h3, 4'h0, 4'h0, 2);
      lwait(8);
      chk(fa[0], 1'b1);
      i_rfaf_reader.read_bytes(53, 1'b0, k == 1);
      chk(fa[0], 1'b1);
      i_rfaf_reader.read_bytes(4 + d[k], 1'b0, 1'b0);
      chk(fa[0], 1'b1);
      i_rfaf_reader.read_bytes(1, 1'b0, 1'b0);
      chk(fa[0], 1'b0);
      if (d[k] < 48) i_rfaf_reader.read_bytes(48 - d[k], 1'b0, 1'b0);
      chk(fa[0], 1'b0);
    end
    chk(fa[1], 1'b1);
    chk(fa[2], 1'b0);
    $display("test atm done");
  endtask
  task automatic test_pos;
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    mode_pos <= 4'h9;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    lwait(4);
    pulse(4'h0, 4'h1, 4'h0, 2);
    lwait(8);
    chk(fa[0], 1'b0);
    chk(fa[3], 1'b1);
    pulse(4'h0, 4'h1, 4'h0, 1);
    lwait(8);
    chk(fa[0], 1'b1);
    i_rfaf_reader.read_bytes(4, 1'b0, 1'b1);
    chk(fa[0], 1'b0);
    pulse(4'h0, 4'h0, 4'h1, 1);
    lwait(8);
    chk(fa[0], 1'b1);
    i_rfaf_reader.read_bytes(8, 1'b1, 1'b0);
    chk(fa[0], 1'b0);
    $display("test pos done");
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    lwait(4);
    test_atm();
    test_pos();
    final_report();
  end
endmodule
